// ===== design/parallel_line_controller.sv
`include "line_consts.svh"

module parallel_line_controller
  import line_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter logic [31:0] MUX_MASK = 32'hffff_ffff,
  parameter logic [31:0] OWNER_RESET = 32'hffff_ffff
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic periph_clk_on,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  output logic [WIDTH-1:0] pullup_en,
  input wire line_drive_t periph_a,
  input wire line_drive_t periph_b,
  output logic [WIDTH-1:0] periph_in,
  output logic irq
);
  if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
    $error("WIDTH must be 1 to 32");
  end
  if (((~OWNER_RESET) & ~MUX_MASK) != 32'h0000_0000) begin : g_bad_owner
    $error("unmuxed lines must reset controller owned");
  end

  logic [WIDTH-1:0] own_reg, own_next;
  logic [WIDTH-1:0] oe_reg, oe_next;
  logic [WIDTH-1:0] flt_reg, flt_next;
  logic [WIDTH-1:0] dat_reg, dat_next;
  logic [WIDTH-1:0] ie_reg, ie_next;
  logic [WIDTH-1:0] chg_reg, chg_next;
  logic [WIDTH-1:0] md_reg, md_next;
  logic [WIDTH-1:0] pu_reg, pu_next;
  logic [WIDTH-1:0] ab_reg, ab_next;
  logic [WIDTH-1:0] ow_reg, ow_next;
  logic [WIDTH-1:0] level_reg, level_next;
  logic [31:0] rd_data_reg, rd_data_next;
  logic clk_en_reg;
  logic irq_reg, irq_next;
  logic [WIDTH-1:0] pin_out_reg, pin_oe_reg, pullup_reg, periph_in_reg;
  logic [WIDTH-1:0] sync_lvl, filt_lvl;
  line_drive_t drive;

  wire [WIDTH-1:0] wd = wdata[WIDTH-1:0];
  wire [WIDTH-1:0] mux_mask = MUX_MASK[WIDTH-1:0];
  wire [WIDTH-1:0] own_rst = OWNER_RESET[WIDTH-1:0];
  wire [31:0] pu_rst = `RST_PULLUP;
  wire [31:0] lvl_rst = `RST_LEVEL;
  wire [WIDTH-1:0] ctl_drv = own_reg & oe_reg & ~md_reg;

  // write decode
  wire wr_own_set = wr_en && addr == `OFS_OWN_SET;
  wire wr_own_clr = wr_en && addr == `OFS_OWN_CLR;
  wire wr_oe_set = wr_en && addr == `OFS_OE_SET;
  wire wr_oe_clr = wr_en && addr == `OFS_OE_CLR;
  wire wr_flt_set = wr_en && addr == `OFS_FLT_SET;
  wire wr_flt_clr = wr_en && addr == `OFS_FLT_CLR;
  wire wr_dat_set = wr_en && addr == `OFS_DAT_SET;
  wire wr_dat_clr = wr_en && addr == `OFS_DAT_CLR;
  wire wr_dat_sync = wr_en && addr == `OFS_DAT_STAT;
  wire wr_ie_set = wr_en && addr == `OFS_IE_SET;
  wire wr_ie_clr = wr_en && addr == `OFS_IE_CLR;
  wire wr_md_set = wr_en && addr == `OFS_MD_SET;
  wire wr_md_clr = wr_en && addr == `OFS_MD_CLR;
  wire wr_pu_dis = wr_en && addr == `OFS_PU_DIS;
  wire wr_pu_en = wr_en && addr == `OFS_PU_EN;
  wire wr_sel_a = wr_en && addr == `OFS_SEL_A;
  wire wr_sel_b = wr_en && addr == `OFS_SEL_B;
  wire wr_ow_set = wr_en && addr == `OFS_OW_SET;
  wire wr_ow_clr = wr_en && addr == `OFS_OW_CLR;
  wire rd_chg = rd_en && addr == `OFS_CHG_STAT;

  wire [WIDTH-1:0] m_own_set = wr_own_set ? wd : '0;
  wire [WIDTH-1:0] m_own_clr = wr_own_clr ? (wd & mux_mask) : '0;
  wire [WIDTH-1:0] m_oe_set = wr_oe_set ? wd : '0;
  wire [WIDTH-1:0] m_oe_clr = wr_oe_clr ? wd : '0;
  wire [WIDTH-1:0] m_flt_set = wr_flt_set ? wd : '0;
  wire [WIDTH-1:0] m_flt_clr = wr_flt_clr ? wd : '0;
  wire [WIDTH-1:0] m_dat_set = wr_dat_set ? wd : '0;
  wire [WIDTH-1:0] m_dat_clr = wr_dat_clr ? wd : '0;
  wire [WIDTH-1:0] m_ow = wr_dat_sync ? ow_reg : '0;
  wire [WIDTH-1:0] m_ie_set = wr_ie_set ? wd : '0;
  wire [WIDTH-1:0] m_ie_clr = wr_ie_clr ? wd : '0;
  wire [WIDTH-1:0] m_md_set = wr_md_set ? wd : '0;
  wire [WIDTH-1:0] m_md_clr = wr_md_clr ? wd : '0;
  wire [WIDTH-1:0] m_pu_dis = wr_pu_dis ? wd : '0;
  wire [WIDTH-1:0] m_pu_en = wr_pu_en ? wd : '0;
  wire [WIDTH-1:0] m_sel_a = wr_sel_a ? wd : '0;
  wire [WIDTH-1:0] m_sel_b = wr_sel_b ? wd : '0;
  wire [WIDTH-1:0] m_ow_set = wr_ow_set ? wd : '0;
  wire [WIDTH-1:0] m_ow_clr = wr_ow_clr ? wd : '0;

  // config registers ignore clk_en_reg on purpose: writes land while gated
  assign own_next = ((own_reg | m_own_set) & ~m_own_clr) | ~mux_mask;
  assign oe_next = (oe_reg | m_oe_set) & ~m_oe_clr;
  assign flt_next = (flt_reg | m_flt_set) & ~m_flt_clr;
  assign dat_next = (((dat_reg | m_dat_set) & ~m_dat_clr) & ~m_ow) | (wd & m_ow);
  assign ie_next = (ie_reg | m_ie_set) & ~m_ie_clr;
  assign md_next = (md_reg | m_md_set) & ~m_md_clr;
  assign pu_next = (pu_reg | m_pu_dis) & ~m_pu_en;
  assign ab_next = (ab_reg | m_sel_b) & ~m_sel_a;
  assign ow_next = (ow_reg | m_ow_set) & ~m_ow_clr;

  // pin sampling frozen while the clock is gated
  assign level_next = clk_en_reg ? filt_lvl : level_reg;
  wire [WIDTH-1:0] change = clk_en_reg ? (filt_lvl ^ level_reg) : '0;
  // a change in the clearing read cycle survives
  assign chg_next = (rd_chg ? '0 : chg_reg) | change;
  // only for sources 2..31 of the interrupt controller
  assign irq_next = clk_en_reg && (|(chg_reg & ie_reg));

  // read mux, unmapped reads give zero
  wire [WIDTH-1:0] rd_sel =
    (addr == `OFS_OWN_STAT) ? own_reg :
    (addr == `OFS_OE_STAT) ? oe_reg :
    (addr == `OFS_FLT_STAT) ? flt_reg :
    (addr == `OFS_DAT_STAT) ? dat_reg :
    (addr == `OFS_PIN_STAT) ? level_reg :
    (addr == `OFS_IE_STAT) ? ie_reg :
    (addr == `OFS_CHG_STAT) ? chg_reg :
    (addr == `OFS_MD_STAT) ? md_reg :
    (addr == `OFS_PU_STAT) ? pu_reg :
    (addr == `OFS_AB_STAT) ? ab_reg :
    (addr == `OFS_OW_STAT) ? ow_reg : '0;
  assign rd_data_next = rd_en ? 32'(rd_sel) : 32'h0000_0000;

  line_input_filter #(
    .WIDTH(WIDTH)
  ) u_filter (
    .mclk(mclk),
    .srst(srst),
    .pin_in(pin_in),
    .filt_en(flt_reg),
    .sync_out(sync_lvl),
    .level_out(filt_lvl)
  );

  line_drive_mux #(
    .WIDTH(WIDTH)
  ) u_mux (
    .owner(own_reg),
    .absel(ab_reg),
    .data(dat_reg),
    .oe(oe_reg),
    .mdrive(md_reg),
    .periph_a(periph_a),
    .periph_b(periph_b),
    .drive(drive)
  );

  always_ff @(posedge mclk) begin
    if (srst) begin
      own_reg <= own_rst;
      oe_reg <= '0;
      flt_reg <= '0;
      dat_reg <= '0;
      ie_reg <= '0;
      md_reg <= '0;
      pu_reg <= pu_rst[WIDTH-1:0];
      ab_reg <= '0;
      ow_reg <= '0;
    end else begin
      own_reg <= own_next;
      oe_reg <= oe_next;
      flt_reg <= flt_next;
      dat_reg <= dat_next;
      ie_reg <= ie_next;
      md_reg <= md_next;
      pu_reg <= pu_next;
      ab_reg <= ab_next;
      ow_reg <= ow_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      clk_en_reg <= 1'b0;
      level_reg <= lvl_rst[WIDTH-1:0];
      chg_reg <= '0;
      irq_reg <= 1'b0;
      rd_data_reg <= `RST_ZERO;
    end else begin
      clk_en_reg <= periph_clk_on;
      level_reg <= level_next;
      chg_reg <= chg_next;
      irq_reg <= irq_next;
      rd_data_reg <= rd_data_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pin_out_reg <= '0;
      pin_oe_reg <= '0;
      pullup_reg <= '1;
      periph_in_reg <= '0;
    end else begin
      pin_out_reg <= drive.val;
      pin_oe_reg <= drive.oe;
      pullup_reg <= ~pu_reg;
      // input path never gated by ownership
      periph_in_reg <= sync_lvl;
    end
  end

  assign rd_data = rd_data_reg;
  assign pin_out = pin_out_reg;
  assign pin_oe = pin_oe_reg;
  assign pullup_en = pullup_reg;
  assign periph_in = periph_in_reg;
  assign irq = irq_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_gated_cfg_write;
    !clk_en_reg && wr_ow_set;
  endsequence

  sequence s_sync_write;
    wr_dat_sync && !wr_dat_set && !wr_dat_clr;
  endsequence

  a_unmuxed_owned: assert property ((own_reg & ~mux_mask) == ~mux_mask)
    else $error("unmuxed line left controller ownership");
  a_pullup_reset: assert property (disable iff (1'b0) srst |=> pu_reg == '0)
    else $error("pull-up status not zero after reset");
  a_irq_gated: assert property (!clk_en_reg |=> !irq_reg)
    else $error("interrupt raised with clock gated");
  a_level_frozen: assert property (!clk_en_reg |=> level_reg == $past(level_reg))
    else $error("pin level moved while clock gated");
  a_change_flag: assert property (clk_en_reg && (filt_lvl != level_reg)
      |=> (chg_reg & $past(filt_lvl ^ level_reg)) == $past(filt_lvl ^ level_reg))
    else $error("line change not flagged");
  a_sync_data: assert property (s_sync_write |=> dat_reg ==
      (($past(dat_reg) & ~$past(ow_reg)) | ($past(wd) & $past(ow_reg))))
    else $error("masked output write wrong");
  a_gated_write: assert property (s_gated_cfg_write |=> (ow_reg & $past(wd)) == $past(wd))
    else $error("config write lost with clock gated");
  a_pullup_read: assert property (rd_en && addr == `OFS_PU_STAT
      |=> rd_data_reg[WIDTH-1:0] == $past(pu_reg))
    else $error("pull-up status read wrong");
  a_owner_drive: assert property ((|ctl_drv) |=> (pin_oe_reg & $past(ctl_drv)) == $past(ctl_drv)
      && (pin_out_reg & $past(ctl_drv)) == ($past(dat_reg) & $past(ctl_drv)))
    else $error("controller owned line not driven from data");
  a_open_drain: assert property ((|md_reg)
      |=> (pin_oe_reg & pin_out_reg & $past(md_reg)) == '0)
    else $error("multi-drive line driven high");
  a_read_zero: assert property (!rd_en |=> rd_data_reg == 32'h0000_0000)
    else $error("read data not zero outside read cycle");
  a_clk_reset: assert property (disable iff (1'b0) srst |=> !clk_en_reg)
    else $error("peripheral clock on after reset");
endmodule : parallel_line_controller

// ===== design/line_consts.svh
`ifndef LINE_CONSTS_SVH
`define LINE_CONSTS_SVH

`define OFS_OWN_SET 8'h00
`define OFS_OWN_CLR 8'h04
`define OFS_OWN_STAT 8'h08
`define OFS_OE_SET 8'h10
`define OFS_OE_CLR 8'h14
`define OFS_OE_STAT 8'h18
`define OFS_FLT_SET 8'h20
`define OFS_FLT_CLR 8'h24
`define OFS_FLT_STAT 8'h28
`define OFS_DAT_SET 8'h30
`define OFS_DAT_CLR 8'h34
`define OFS_DAT_STAT 8'h38
`define OFS_PIN_STAT 8'h3c
`define OFS_IE_SET 8'h40
`define OFS_IE_CLR 8'h44
`define OFS_IE_STAT 8'h48
`define OFS_CHG_STAT 8'h4c
`define OFS_MD_SET 8'h50
`define OFS_MD_CLR 8'h54
`define OFS_MD_STAT 8'h58
`define OFS_PU_DIS 8'h60
`define OFS_PU_EN 8'h64
`define OFS_PU_STAT 8'h68
`define OFS_SEL_A 8'h70
`define OFS_SEL_B 8'h74
`define OFS_AB_STAT 8'h78
`define OFS_OW_SET 8'ha0
`define OFS_OW_CLR 8'ha4
`define OFS_OW_STAT 8'ha8

`define RST_ZERO 32'h0000_0000
`define RST_PULLUP 32'h0000_0000
`define RST_LEVEL 32'hffff_ffff
`endif

// ===== design/line_pkg.sv
package line_pkg;
  typedef struct packed {
    logic [31:0] val;
    logic [31:0] oe;
  } line_drive_t;
endpackage : line_pkg

// ===== design/line_input_filter.sv
module line_input_filter
  import line_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] filt_en,
  output logic [WIDTH-1:0] sync_out,
  output logic [WIDTH-1:0] level_out
);
  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_line
      logic s1_reg, s2_reg, s3_reg, sync_reg, prev_reg, prev2_reg, filt_reg;
      // s1 feeds only s2; change counts once s2 and s3 agree
      // reset to the idle level of a pulled-up pin, so no false edge follows reset
      always_ff @(posedge mclk) begin
        if (srst) begin
          s1_reg <= 1'b1;
          s2_reg <= 1'b1;
          s3_reg <= 1'b1;
          sync_reg <= 1'b1;
          prev_reg <= 1'b1;
          prev2_reg <= 1'b1;
          filt_reg <= 1'b1;
        end else begin
          s1_reg <= pin_in[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            sync_reg <= s3_reg;
          end
          prev_reg <= sync_reg;
          prev2_reg <= prev_reg;
          // sync stage already drops one-sample pulses; filter drops two-sample ones too
          if (!filt_en[i] || (prev_reg == sync_reg && prev2_reg == sync_reg)) begin
            filt_reg <= sync_reg;
          end
        end
      end
      assign sync_out[i] = sync_reg;
      assign level_out[i] = filt_reg;
    end
  endgenerate
endmodule : line_input_filter

// ===== design/line_drive_mux.sv
module line_drive_mux
  import line_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input wire logic [WIDTH-1:0] owner,
  input wire logic [WIDTH-1:0] absel,
  input wire logic [WIDTH-1:0] data,
  input wire logic [WIDTH-1:0] oe,
  input wire logic [WIDTH-1:0] mdrive,
  input wire line_drive_t periph_a,
  input wire line_drive_t periph_b,
  output line_drive_t drive
);
  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_line
      wire sel_val = owner[i] ? data[i] : (absel[i] ? periph_b.val[i] : periph_a.val[i]);
      wire sel_oe = owner[i] ? oe[i] : (absel[i] ? periph_b.oe[i] : periph_a.oe[i]);
      // open drain: only ever drive low
      assign drive.val[i] = sel_val & ~mdrive[i];
      assign drive.oe[i] = sel_oe & ~(mdrive[i] & sel_val);
    end
  endgenerate
endmodule : line_drive_mux

// ===== tb/pin_partner.sv
module pin_partner
  import line_pkg::*;
(
  input wire logic mclk,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] pullup_en,
  input wire logic [31:0] ext_val,
  input wire logic [31:0] ext_oe,
  output logic [31:0] pin_in,
  output line_drive_t periph_a,
  output line_drive_t periph_b
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pat = 1'b0;
  always @(posedge mclk) begin
    pat <= ~pat;
  end
  // device drive wins a clash; floating lines without pull-up wander each cycle
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
    | (~pin_oe & ~ext_oe & (pullup_en | {32{pat}}));
  assign periph_a = {32'h3c3c_a5a5, 32'h0f0f_f0f0};
  assign periph_b = {32'hc3c3_5a5a, 32'hff00_ff00};
endmodule : pin_partner

// ===== tb/testbench.sv
module testbench
  import line_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic mclk = 1'b0;
  logic srst, wr_en, rd_en, periph_clk_on, irq, rd_seen;
  logic [7:0] addr;
  logic [31:0] wdata, rd_data, pin_in, pin_out, pin_oe, pullup_en, periph_in;
  logic [31:0] ext_val, ext_oe, r, cur, eo, qm, qe;
  line_drive_t pa, pb;
  logic [31:0] exp_q[$], mask_q[$];
  string name_q[$];
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;

  parallel_line_controller #(.MUX_MASK(32'h0000_ffff)) uut (
    .mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .periph_clk_on(periph_clk_on), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pullup_en(pullup_en), .periph_a(pa), .periph_b(pb),
    .periph_in(periph_in), .irq(irq));
  pin_partner far_side (
    .mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
    .ext_val(ext_val), .ext_oe(ext_oe), .pin_in(pin_in), .periph_a(pa), .periph_b(pb));

  always #50 mclk = ~mclk;

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
    checked++;
    if (seen !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, seen);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
    input string nm);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    mask_q.push_back(m);
    name_q.push_back(nm);
    @(posedge mclk);
    rd_en <= 1'b0;
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle

  // read data stand only in the cycle after the strobe
  always @(posedge mclk) begin
    if (rd_seen === 1'b1 && exp_q.size() > 0) begin
      qm = mask_q.pop_front();
      qe = exp_q.pop_front();
      check(name_q.pop_front(), rd_data & qm, qe & qm);
    end
    rd_seen <= rd_en;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      report_and_stop();
    end
  end

  initial begin
    srst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    periph_clk_on = 1'b0;
    ext_val = 32'h0000_0000;
    ext_oe = 32'h0000_0000;
    r = $urandom(90674);
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    rd(8'h68, 32'h0, ALL, "pullup_status");
    rd(8'h08, ALL, ALL, "line_owner_status");
    rd(8'h58, 32'h0, ALL, "multi_drive");
    rd(8'ha8, 32'h0, ALL, "sync_mask");
    rd(8'hfc, 32'h0, ALL, "unmapped");
    rd(8'h3c, ALL, ALL, "pin_level_gated");
    settle(2);
    check("pullup_en", pullup_en, ALL);
    r = $urandom;
    wr(8'h60, r);
    rd(8'h68, r, ALL, "pullup_status");
    wr(8'ha0, r);
    rd(8'ha8, r, ALL, "sync_mask_gated");
    wr(8'ha4, ALL);
    settle(2);
    check("pullup_en", pullup_en, ~r);
    wr(8'h64, ALL);
    periph_clk_on <= 1'b1;
    r = $urandom;
    ext_oe <= 32'hffff_ff0f;
    ext_val <= r;
    cur = (r & 32'hffff_ff0f) | 32'h0000_00f0;
    settle(10);
    rd(8'h3c, cur, ALL, "pin_level");
    check("periph_in", periph_in, cur);
    rd(8'h4c, 32'h0, 32'h0, "chg_clear");
    wr(8'h40, 32'h1);
    ext_val <= r ^ 32'h1;
    settle(10);
    check("irq", {31'h0, irq}, 32'h1);
    rd(8'h4c, 32'h1, ALL, "chg_status");
    settle(4);
    check("irq", {31'h0, irq}, 32'h0);
    ext_val <= r ^ 32'h3;
    settle(10);
    check("irq", {31'h0, irq}, 32'h0);
    rd(8'h4c, 32'h2, ALL, "chg_status");
    wr(8'h20, 32'h8);
    ext_val <= r ^ 32'hb;
    repeat (2) @(posedge mclk);
    ext_val <= r ^ 32'h3;
    settle(10);
    rd(8'h4c, 32'h0, ALL, "chg_filtered");
    ext_val <= r ^ 32'hb;
    settle(10);
    rd(8'h4c, 32'h8, ALL, "chg_filter_pass");
    cur = cur ^ 32'hb;
    periph_clk_on <= 1'b0;
    repeat (3) @(posedge mclk);
    ext_val <= r ^ 32'ha;
    settle(10);
    check("irq", {31'h0, irq}, 32'h0);
    rd(8'h3c, cur, ALL, "pin_level_frozen");
    wr(8'h44, ALL);
    rd(8'h48, 32'h0, ALL, "irq_mask");
    cur = cur ^ 32'h1;
    periph_clk_on <= 1'b1;
    settle(10);
    rd(8'h4c, 32'h0, 32'h0, "chg_clear");
    wr(8'h10, 32'h0000_00f0);
    wr(8'h30, 32'h0000_00a0);
    settle(2);
    check("pin_oe", pin_oe, 32'h0000_00f0);
    check("pin_out", pin_out & 32'h0000_00f0, 32'h0000_00a0);
    wr(8'ha0, 32'h0000_0030);
    wr(8'h38, ALL);
    rd(8'h38, 32'h0000_00b0, ALL, "data_status");
    wr(8'h50, 32'h0000_00f0);
    settle(2);
    check("pin_oe_md", pin_oe, 32'h0000_0040);
    check("pin_out_md", pin_out & 32'h0000_00f0, 32'h0);
    settle(8);
    rd(8'h3c, (cur & 32'hffff_ff0f) | 32'h0000_00b0, ALL, "pin_level_md");
    wr(8'h54, ALL);
    ext_oe <= 32'h0;
    wr(8'h04, ALL);
    rd(8'h08, 32'hffff_0000, ALL, "line_owner_status");
    wr(8'h74, 32'h0000_00ff);
    rd(8'h78, 32'h0000_00ff, ALL, "ab_status");
    settle(2);
    eo = (pb.oe & 32'h0000_00ff) | (pa.oe & 32'h0000_ff00);
    check("pin_oe_periph", pin_oe, eo);
    check("pin_out_periph", pin_out & eo,
      ((pb.val & 32'h0000_00ff) | (pa.val & 32'h0000_ff00)) & eo);
    wr(8'h00, ALL);
    rd(8'h08, ALL, ALL, "line_owner_status");
    settle(2);
    check("pin_oe_ctrl", pin_oe, 32'h0000_00f0);
    settle(3);
    report_and_stop();
  end
endmodule : testbench
